// *** rtl/wbc_defines.vh ***
// Constants for the weather-band status, gain-loop and output command block.
// Assumes an APB slave on pclk at 20 MHz with 32-bit data.
// Summary of operation
// RULE_01 - Bytes 4,5 pack eight 2-bit confidences
// RULE_02 - Bytes 6..13 read buffer from start offset
// RULE_03 - Opcode 0x55 answers status plus two bytes
// RULE_04 - Acknowledge bit clears alert int and stickies
// RULE_05 - Tone-absent sticky until tune or acknowledge
// RULE_06 - Tone-present sticky until tune or acknowledge
// RULE_07 - Byte 2 bit 0 shows live tone
// RULE_08 - Clear-to-send set when next command allowed
// RULE_09 - Host commands only while powered up
// RULE_10 - Opcode 0x57 returns gain-loop-off readback bit
// RULE_11 - Opcode 0x58 bit 0 disables gain loop
// RULE_12 - Override holds fixed gain step 0..26
// RULE_13 - Opcode 0x80 sets pin drive enables
// RULE_14 - Pin 2 interrupt function overrides drive setting
// RULE_15 - Opcode 0x81 sets pin output levels
// RULE_16 - Host should not leave pins floating
// RULE_17 - Status low byte carries all event flags
// RULE_18 - Buffer read always returns eight bytes
// RULE_19 - Status byte first, then responses ascending
`ifndef WBC_DEFINES_VH
`define WBC_DEFINES_VH
// Register byte addresses
`define WBC_ADDR_CMD      12'h000
`define WBC_ADDR_ARG      12'h004
`define WBC_ADDR_STATUS   12'h008
`define WBC_ADDR_RESP     12'h00C
`define WBC_ADDR_INT_STAT 12'h010
`define WBC_ADDR_INT_MASK 12'h014
`define WBC_ADDR_CONFIG   12'h018
`define WBC_ADDR_GAIN     12'h01C
// Opcodes
`define WBC_OP_MSG_READ   8'h54
`define WBC_OP_TONE_STAT  8'h55
`define WBC_OP_GAIN_STAT  8'h57
`define WBC_OP_GAIN_OVR   8'h58
`define WBC_OP_OUT_DRIVE  8'h80
`define WBC_OP_OUT_LEVEL  8'h81
// Status byte bit positions
`define WBC_ST_CTS        7
`define WBC_ST_ERR        6
`define WBC_ST_SQ         3
`define WBC_ST_MSG        2
`define WBC_ST_TONE       1
`define WBC_ST_TUNE       0
// Argument field positions
`define WBC_ARG_ACK       0
`define WBC_ARG_PIN1      1
`define WBC_ARG_PIN3      3
// Response sizes
`define WBC_RESP_MSG      4'hD
`define WBC_RESP_TONE     4'h2
`define WBC_RESP_GAIN     4'h1
`define WBC_RESP_NONE     4'h0
`define WBC_DATA_FIRST    6
`define WBC_MSG_BYTES     8
// Gain step limit and reset values
`define WBC_GAIN_MAX      5'h1A
`define WBC_RST_MASK      8'h00
`define WBC_RST_GAIN      5'h00
`endif

// *** rtl/wbc_cmd_engine.v ***
// Command interpreter: message-buffer read tail, alert tone status,
// gain-loop status and override, and three general-purpose outputs.
// Assumes an APB master on pclk, a message decoder writing the buffer on
// the same clock, and a tone detector level arriving from another domain.
`timescale 1ns/1ps
`include "wbc_defines.vh"
module wbc_cmd_engine (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Message decoder (same clock)
  input  wire        msg_wr_en,
  input  wire [7:0]  msg_wr_addr,
  input  wire [7:0]  msg_wr_data,
  input  wire [1:0]  msg_wr_conf,
  input  wire [7:0]  msg_flags,
  input  wire [7:0]  msg_state,
  input  wire [7:0]  message_length,
  input  wire        msg_event,
  // Receiver events (same clock)
  input  wire        sq_event,
  input  wire        tune_done,
  input  wire        tune_cmd,
  input  wire [4:0]  auto_gain_step,
  // Tone detector (asynchronous level)
  input  wire        tone_present,
  // Outputs
  output reg  [4:0]  lna_gain_step,
  output reg         rf_gain_loop_off,
  output reg         out_pin_1,
  output reg         out_pin_1_oe,
  output reg         out_pin_2,
  output reg         out_pin_2_oe,
  output reg         out_pin_3,
  output reg         out_pin_3_oe,
  output reg         irq
);

  localparam ST_IDLE = 1'b0;  // Waiting for a command
  localparam ST_EXEC = 1'b1;  // Executing the latched command

  // Message buffer: data byte plus confidence per address
  reg  [9:0] msg_mem [0:255];
  // Response bytes 1..13, index 0 holds byte 1
  reg  [7:0] resp_q [0:12];

  reg        state_q;          // Engine state
  reg  [7:0] opcode_q;         // Latched opcode
  reg  [7:0] arg1_q;           // Argument byte 1
  reg  [7:0] arg2_q;           // Argument byte 2 (start offset)
  reg  [3:0] resp_len_q;       // Response bytes of the last command
  reg  [3:0] rd_ptr_q;         // Next byte in the read stream
  reg        cts_q;            // Clear to send
  reg        err_q;            // Last command rejected
  reg  [3:0] int_q;            // Sticky event flags, status bits 3..0
  reg  [7:0] mask_q;           // Interrupt mask, same layout as status
  reg        pin2_irq_q;       // Pin 2 carries the interrupt request
  reg  [4:0] fixed_gain_q;     // Gain step held while overridden
  reg        absent_sticky_q;  // tone_absent_sticky
  reg        present_sticky_q; // tone_present_sticky
  reg  [2:0] drive_en_q;       // Drive enables of pins 3..1
  reg  [2:0] level_q;          // Levels of pins 3..1
  reg        tone_s1_q;        // Synchroniser first stage
  reg        tone_s2_q;        // Synchroniser second stage
  reg        tone_q;           // Delayed copy for edge detection

  wire [7:0] status_byte;
  wire       acc_done;
  wire       wr_done;
  wire       rd_done;
  wire       cmd_go;
  wire       ack_go;
  wire       tone_rise;
  wire       tone_fall;
  wire [3:0] w1c;
  reg  [31:0] rd_val;
  reg        rd_bad;
  reg  [7:0] stream_byte;
  integer    i;

  // Live status byte: clear-to-send, error and event flags (see RULE_17)
  assign status_byte = {cts_q, err_q, 2'b00, int_q};

  // A transfer completes on the edge where pready is seen high
  assign acc_done = psel & penable & pready;
  assign wr_done  = acc_done & pwrite;
  assign rd_done  = acc_done & ~pwrite;
  // Commands written while busy are dropped (see RULE_08)
  assign cmd_go   = wr_done & (paddr == `WBC_ADDR_CMD) & cts_q;
  assign ack_go   = (state_q == ST_EXEC) & (opcode_q == `WBC_OP_TONE_STAT)
                    & arg1_q[`WBC_ARG_ACK];
  assign tone_rise = tone_s2_q & ~tone_q;
  assign tone_fall = ~tone_s2_q & tone_q;
  assign w1c = (wr_done & (paddr == `WBC_ADDR_INT_STAT)) ? pwdata[3:0]
               : 4'h0;

  // Next byte of the read stream: status first, then bytes ascending
  always @* begin
    stream_byte = 8'h00;
    if (rd_ptr_q == 4'h0) begin
      stream_byte = status_byte;  // see RULE_19
    end else if (rd_ptr_q <= resp_len_q) begin
      stream_byte = resp_q[rd_ptr_q - 4'h1];  // see RULE_19
    end
  end

  // Read decode; unmapped addresses answer with an error
  always @* begin
    rd_val = 32'h0000_0000;
    rd_bad = 1'b0;
    if (paddr == `WBC_ADDR_CMD) begin
      rd_val = {24'h00_0000, opcode_q};
    end else if (paddr == `WBC_ADDR_ARG) begin
      rd_val = {16'h0000, arg2_q, arg1_q};
    end else if (paddr == `WBC_ADDR_STATUS) begin
      rd_val = {24'h00_0000, status_byte};
    end else if (paddr == `WBC_ADDR_RESP) begin
      rd_val = {24'h00_0000, stream_byte};
    end else if (paddr == `WBC_ADDR_INT_STAT) begin
      rd_val = {24'h00_0000, status_byte};
    end else if (paddr == `WBC_ADDR_INT_MASK) begin
      rd_val = {24'h00_0000, mask_q};
    end else if (paddr == `WBC_ADDR_CONFIG) begin
      rd_val = {31'h0000_0000, pin2_irq_q};
    end else if (paddr == `WBC_ADDR_GAIN) begin
      rd_val = {27'h000_0000, fixed_gain_q};
    end else begin
      rd_bad = 1'b1;
    end
  end

  // APB answer: one wait state so that read data comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= rd_bad;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Two flops before the tone detector level is looked at
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_s1_q <= 1'b0;
      tone_s2_q <= 1'b0;
      tone_q    <= 1'b0;
    end else begin
      tone_s1_q <= tone_present;
      tone_s2_q <= tone_s1_q;
      tone_q    <= tone_s2_q;
    end
  end

  // Message buffer write port; no reset, contents undefined until written
  always @(posedge pclk) begin
    if (msg_wr_en) begin
      msg_mem[msg_wr_addr] <= {msg_wr_conf, msg_wr_data};
    end
  end

  // Alert stickies: a new edge wins over tune or acknowledge clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      absent_sticky_q  <= 1'b0;
      present_sticky_q <= 1'b0;
    end else begin
      if (tone_fall) begin
        absent_sticky_q <= 1'b1;  // see RULE_05
      end else if (tune_cmd | ack_go) begin
        absent_sticky_q <= 1'b0;  // see RULE_05
      end
      if (tone_rise) begin
        present_sticky_q <= 1'b1;  // see RULE_06
      end else if (tune_cmd | ack_go) begin
        present_sticky_q <= 1'b0;  // see RULE_04
      end
    end
  end

  // Sticky event flags; set beats software or acknowledge clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 4'h0;
    end else begin
      if (sq_event) begin
        int_q[`WBC_ST_SQ] <= 1'b1;
      end else if (w1c[`WBC_ST_SQ]) begin
        int_q[`WBC_ST_SQ] <= 1'b0;
      end
      if (msg_event) begin
        int_q[`WBC_ST_MSG] <= 1'b1;
      end else if (w1c[`WBC_ST_MSG]) begin
        int_q[`WBC_ST_MSG] <= 1'b0;
      end
      if (tone_rise | tone_fall) begin
        int_q[`WBC_ST_TONE] <= 1'b1;
      end else if (w1c[`WBC_ST_TONE] | ack_go) begin
        int_q[`WBC_ST_TONE] <= 1'b0;  // see RULE_04
      end
      if (tune_done) begin
        int_q[`WBC_ST_TUNE] <= 1'b1;
      end else if (w1c[`WBC_ST_TUNE]) begin
        int_q[`WBC_ST_TUNE] <= 1'b0;
      end
    end
  end

  // Software configuration: mask, pin 2 function, fixed gain step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q       <= `WBC_RST_MASK;
      pin2_irq_q   <= 1'b0;
      fixed_gain_q <= `WBC_RST_GAIN;
    end else if (wr_done) begin
      if (paddr == `WBC_ADDR_INT_MASK) begin
        mask_q <= pwdata[7:0];
      end else if (paddr == `WBC_ADDR_CONFIG) begin
        pin2_irq_q <= pwdata[0];
      end else if (paddr == `WBC_ADDR_GAIN) begin
        // Clamp rather than wrap so the step stays in range (see RULE_12)
        fixed_gain_q <= (pwdata[4:0] > `WBC_GAIN_MAX) ? `WBC_GAIN_MAX
                        : pwdata[4:0];
      end
    end
  end

  // Argument register written ahead of the opcode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg1_q <= 8'h00;
      arg2_q <= 8'h00;
    end else if (wr_done & (paddr == `WBC_ADDR_ARG) & cts_q) begin
      arg1_q <= pwdata[7:0];
      arg2_q <= pwdata[15:8];
    end
  end

  // Command engine: accept, execute in one cycle, raise clear-to-send
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= ST_IDLE;
      opcode_q         <= 8'h00;
      resp_len_q       <= `WBC_RESP_NONE;
      rd_ptr_q         <= 4'h0;
      cts_q            <= 1'b1;
      err_q            <= 1'b0;
      rf_gain_loop_off <= 1'b0;
      drive_en_q       <= 3'b000;
      level_q          <= 3'b000;
      for (i = 0; i < 13; i = i + 1) begin
        resp_q[i] <= 8'h00;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_go) begin
            opcode_q <= pwdata[7:0];
            cts_q    <= 1'b0;
            err_q    <= 1'b0;
            rd_ptr_q <= 4'h0;
            state_q  <= ST_EXEC;
          end else if (rd_done & (paddr == `WBC_ADDR_RESP)
                       & (rd_ptr_q <= resp_len_q)) begin
            rd_ptr_q <= rd_ptr_q + 4'h1;  // see RULE_19
          end
        end
        ST_EXEC: begin
          cts_q   <= 1'b1;  // see RULE_08
          state_q <= ST_IDLE;
          for (i = 0; i < 13; i = i + 1) begin
            resp_q[i] <= 8'h00;
          end
          case (opcode_q)
            `WBC_OP_MSG_READ: begin
              resp_len_q <= `WBC_RESP_MSG;
              resp_q[0]  <= msg_flags;
              resp_q[1]  <= msg_state;
              resp_q[2]  <= message_length;
              // Always eight bytes; host trims by length (see RULE_18)
              for (i = 0; i < `WBC_MSG_BYTES; i = i + 1) begin
                // Highest byte's confidence in the top bits (see RULE_01)
                if (i < 4) begin
                  resp_q[4][2*i +: 2] <=
                    msg_mem[buf_addr(arg2_q, i[3:0])][9:8];
                end else begin
                  resp_q[3][2*(i-4) +: 2] <=
                    msg_mem[buf_addr(arg2_q, i[3:0])][9:8];
                end
                // Consecutive bytes from the start offset (see RULE_02)
                resp_q[`WBC_DATA_FIRST - 1 + i] <=
                  msg_mem[buf_addr(arg2_q, i[3:0])][7:0];
              end
            end
            `WBC_OP_TONE_STAT: begin
              resp_len_q <= `WBC_RESP_TONE;  // see RULE_03
              // Stickies as they stood before any acknowledge
              resp_q[0] <= {6'h00, absent_sticky_q, present_sticky_q};
              resp_q[1] <= {7'h00, tone_s2_q};  // see RULE_07
            end
            `WBC_OP_GAIN_STAT: begin
              resp_len_q <= `WBC_RESP_GAIN;
              resp_q[0]  <= {7'h00, rf_gain_loop_off};  // see RULE_10
            end
            `WBC_OP_GAIN_OVR: begin
              resp_len_q       <= `WBC_RESP_NONE;
              rf_gain_loop_off <= arg1_q[`WBC_ARG_ACK];  // see RULE_11
            end
            `WBC_OP_OUT_DRIVE: begin
              resp_len_q <= `WBC_RESP_NONE;
              drive_en_q <=
                arg1_q[`WBC_ARG_PIN3:`WBC_ARG_PIN1];  // see RULE_13
            end
            `WBC_OP_OUT_LEVEL: begin
              resp_len_q <= `WBC_RESP_NONE;
              level_q    <=
                arg1_q[`WBC_ARG_PIN3:`WBC_ARG_PIN1];  // see RULE_15
            end
            default: begin
              resp_len_q <= `WBC_RESP_NONE;
              err_q      <= 1'b1;
            end
          endcase
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered outputs: gain step, interrupt and general-purpose pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lna_gain_step <= `WBC_RST_GAIN;
      irq           <= 1'b0;
      out_pin_1     <= 1'b0;
      out_pin_1_oe  <= 1'b0;
      out_pin_2     <= 1'b0;
      out_pin_2_oe  <= 1'b0;
      out_pin_3     <= 1'b0;
      out_pin_3_oe  <= 1'b0;
    end else begin
      // Hold a fixed step while the loop is off (see RULE_12)
      lna_gain_step <= rf_gain_loop_off ? fixed_gain_q : auto_gain_step;
      irq           <= |(status_byte & mask_q);
      out_pin_1     <= level_q[0];
      out_pin_1_oe  <= drive_en_q[0];  // see RULE_13
      out_pin_3     <= level_q[2];
      out_pin_3_oe  <= drive_en_q[2];
      if (pin2_irq_q) begin
        // Interrupt request is active low and always driven (see RULE_14)
        out_pin_2    <= ~(|(status_byte & mask_q));
        out_pin_2_oe <= 1'b1;
      end else begin
        out_pin_2    <= level_q[1];  // see RULE_15
        out_pin_2_oe <= drive_en_q[1];
      end
    end
  end

  // Buffer address of the n-th returned byte; kept 8 bits wide so a read
  // that starts near the top wraps to address 0 instead of running off
  function [7:0] buf_addr;
    input [7:0] start;
    input [3:0] n;
    begin
      buf_addr = start + {4'h0, n};
    end
  endfunction

endmodule

// *** sim/wbc_cmd_engine_asserts.sv ***
// Checker for the command block: bus answer timing, gain hold, pin updates.
// Bound to every wbc_cmd_engine; it sees only that module's ports.
`timescale 1ns/1ps
module wbc_cmd_engine_asserts (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  // Gain loop and pins
  input wire [4:0]  auto_gain_step,
  input wire [4:0]  lna_gain_step,
  input wire        rf_gain_loop_off,
  input wire        out_pin_1,
  input wire        out_pin_1_oe,
  input wire        out_pin_3,
  input wire        out_pin_3_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] since_q; // Cycles since a command write, saturating
  logic [3:0] since_d; // Next count
  // Restart on a command write; pins may only move shortly after one
  always_comb begin
    since_d = (since_q == 4'hF) ? since_q : since_q + 4'h1;
    if (psel && penable && pwrite && paddr == 12'h000) begin
      since_d = 4'h0;
    end
  end
  // Count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 4'hF;
    end else begin
      since_q <= since_d;
    end
  end
  rdy_pulse_a:
    assert property (pready |=> !pready) else $error("pready too long");
  rdy_access_a:
    assert property (pready |-> psel && penable) else $error("stray pready");
  rdy_bound_a:
    assert property (psel && penable |-> ##[0:2] pready)
    else $error("no pready");
  err_rdy_a:
    assert property (pslverr |-> pready) else $error("pslverr alone");
  gain_clamp_a:
    assert property (rf_gain_loop_off && $past(rf_gain_loop_off)
      |-> lna_gain_step <= 5'h1A) else $error("gain step above top");
  gain_follow_a:
    assert property (!rf_gain_loop_off && !$past(rf_gain_loop_off)
      && !$past(rf_gain_loop_off, 2) && $past(presetn) |-> lna_gain_step
      == $past(auto_gain_step)) else $error("gain not following loop");
  pin_cmd_a:
    assert property ($changed({out_pin_1, out_pin_1_oe, out_pin_3,
      out_pin_3_oe}) |-> since_q < 4'h6) else $error("pin moved alone");
  loop_cmd_a:
    assert property ($changed(rf_gain_loop_off) |-> since_q < 4'h6)
    else $error("loop moved alone");
endmodule
bind wbc_cmd_engine wbc_cmd_engine_asserts wbc_cmd_engine_asserts_i (.*);

// *** sim/wbc_host.sv ***
// Host controller model: APB transfers and the command handshake.
// Assumes pclk from the bench; the slave answers with pready in time.
`timescale 1ns/1ps
module wbc_host (
  // Clock
  input  wire         pclk,
  // APB request
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  // APB answer
  input  wire  [31:0] prdata,
  input  wire         pready,
  input  wire         pslverr
);
  logic [31:0] rdata_q; // Last read word
  logic        err_q;   // Last error flag
  // One transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage, not the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Poll status until the next command may go
  task automatic wait_cts;
    do xfer(1'b0, 12'h008, 32'h0); while (rdata_q[7] !== 1'b1);
  endtask
  // Issued only after reset, the powered-up state here
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    wait_cts();
    xfer(1'b1, 12'h004, {16'h0, arg});
    xfer(1'b1, 12'h000, {24'h0, op});
    wait_cts();
  endtask
endmodule

// *** sim/wbc_cmd_engine_bench.sv ***
// Testbench for the command block; the host model drives the bus.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module wbc_cmd_engine_bench;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic msg_wr_en = 0, tune_cmd = 0, sq_event = 0, tone_present = 0;
  logic msg_event = 0, tune_done = 0;
  logic [7:0] msg_wr_addr = 0, msg_wr_data = 0, msg_flags = 0;
  logic [7:0] msg_state = 0, message_length = 0;
  logic [1:0] msg_wr_conf = 0;
  logic [4:0] auto_gain_step = 5'h11, lna_gain_step;
  logic rf_gain_loop_off, irq, out_pin_1, out_pin_2, out_pin_3;
  logic out_pin_1_oe, out_pin_2_oe, out_pin_3_oe;
  int fails = 0, check_count = 0;
  always #25 pclk = ~pclk;
  wbc_host wbc_host_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  wbc_cmd_engine wbc_cmd_engine_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_wr_en(msg_wr_en), .msg_wr_addr(msg_wr_addr),
    .msg_wr_data(msg_wr_data), .msg_wr_conf(msg_wr_conf),
    .msg_flags(msg_flags), .msg_state(msg_state),
    .message_length(message_length), .msg_event(msg_event),
    .sq_event(sq_event), .tune_done(tune_done), .tune_cmd(tune_cmd),
    .auto_gain_step(auto_gain_step), .tone_present(tone_present),
    .lna_gain_step(lna_gain_step), .rf_gain_loop_off(rf_gain_loop_off),
    .out_pin_1(out_pin_1), .out_pin_1_oe(out_pin_1_oe),
    .out_pin_2(out_pin_2), .out_pin_2_oe(out_pin_2_oe),
    .out_pin_3(out_pin_3), .out_pin_3_oe(out_pin_3_oe), .irq(irq));
  // Compare and count
  task automatic chk(input logic [7:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Next word of the response stream
  task automatic rsp(input logic [7:0] exp, input string what);
    wbc_host_i.xfer(1'b0, 12'h00C, 32'h0);
    chk(wbc_host_i.rdata_q[7:0], exp, what);
    chk({7'h0, |wbc_host_i.rdata_q[31:8]}, 8'h0, "upper bits");
  endtask
  // Pause for the tone synchroniser
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  // Reset state and a refused address
  task automatic t_reset;
    wbc_host_i.xfer(1'b0, 12'h008, 32'h0);
    chk(wbc_host_i.rdata_q[7:0], 8'h80, "status at reset");
    wbc_host_i.xfer(1'b0, 12'h020, 32'h0);
    chk({7'h0, wbc_host_i.err_q}, 8'h01, "unmapped");
    chk({5'h0, out_pin_3_oe, out_pin_2_oe, out_pin_1_oe}, 8'h0, "hi-z");
    $display("test reset done");
  endtask
  // Buffer read across the wrap of the start offset
  task automatic t_msg;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      msg_wr_en <= 1'b1;
      msg_wr_addr <= 8'hFE + i[7:0];
      msg_wr_data <= 8'hA0 + i[7:0];
      msg_wr_conf <= i[2:1];
    end
    @(posedge pclk);
    msg_wr_en <= 1'b0;
    msg_flags <= 8'h0F;
    msg_state <= 8'h03;
    message_length <= 8'h05;
    wbc_host_i.cmd(8'h54, 16'hFE00);
    rsp(8'h80, "status first");
    rsp(8'h0F, "flags");
    rsp(8'h03, "state");
    rsp(8'h05, "length");
    rsp(8'hFA, "conf 7..4");
    rsp(8'h50, "conf 3..0");
    for (int i = 0; i < 8; i++) rsp(8'hA0 + i[7:0], "data");
    rsp(8'h00, "past end");
    $display("test message read done");
  endtask
  // Tone stickies, acknowledge, tune clear and interrupt
  task automatic t_tone;
    wbc_host_i.xfer(1'b1, 12'h014, 32'h0A);
    wbc_host_i.xfer(1'b0, 12'h014, 32'h0);
    chk(wbc_host_i.rdata_q[7:0], 8'h0A, "mask readback");
    @(posedge pclk);
    tone_present <= 1'b1;
    settle();
    tone_present <= 1'b0;
    settle();
    chk({7'h0, irq}, 8'h01, "irq on tone");
    wbc_host_i.cmd(8'h55, 16'h0000);
    rsp(8'h82, "tone flag");
    rsp(8'h03, "stickies");
    rsp(8'h00, "live absent");
    tone_present <= 1'b1;
    settle();
    wbc_host_i.cmd(8'h55, 16'h0001);
    rsp(8'h80, "flag cleared by ack");
    rsp(8'h03, "stickies before ack");
    rsp(8'h01, "live present");
    chk({7'h0, irq}, 8'h00, "irq after ack");
    wbc_host_i.cmd(8'h55, 16'h0000);
    rsp(8'h80, "flag cleared");
    rsp(8'h00, "stickies cleared");
    tone_present <= 1'b0;
    settle();
    tune_cmd <= 1'b1;
    @(posedge pclk);
    tune_cmd <= 1'b0;
    wbc_host_i.cmd(8'h55, 16'h0000);
    rsp(8'h82, "flag kept");
    rsp(8'h00, "stickies after tune");
    sq_event <= 1'b1;
    msg_event <= 1'b1;
    tune_done <= 1'b1;
    @(posedge pclk);
    sq_event <= 1'b0;
    msg_event <= 1'b0;
    tune_done <= 1'b0;
    wbc_host_i.xfer(1'b0, 12'h010, 32'h0);
    chk(wbc_host_i.rdata_q[7:0], 8'h8F, "all flags");
    chk({7'h0, irq}, 8'h01, "irq on sq");
    wbc_host_i.xfer(1'b1, 12'h010, 32'h0F);
    settle();
    chk({7'h0, irq}, 8'h00, "irq after clear");
    wbc_host_i.xfer(1'b0, 12'h008, 32'h0);
    chk(wbc_host_i.rdata_q[7:0], 8'h80, "status clear");
    $display("test tone done");
  endtask
  // Gain loop status and override
  task automatic t_gain;
    wbc_host_i.cmd(8'h57, 16'h0000);
    rsp(8'h80, "gain status");
    rsp(8'h00, "loop on");
    chk({3'h0, lna_gain_step}, 8'h11, "auto step");
    wbc_host_i.xfer(1'b1, 12'h01C, 32'h1F);
    wbc_host_i.xfer(1'b0, 12'h01C, 32'h0);
    chk(wbc_host_i.rdata_q[7:0], 8'h1A, "clamped step");
    wbc_host_i.cmd(8'h58, 16'h0001);
    rsp(8'h80, "override status");
    rsp(8'h00, "no bytes");
    chk({7'h0, rf_gain_loop_off}, 8'h01, "loop off");
    chk({3'h0, lna_gain_step}, 8'h1A, "held step");
    wbc_host_i.cmd(8'h57, 16'h0000);
    rsp(8'h80, "gain status");
    rsp(8'h01, "off readback");
    wbc_host_i.cmd(8'h58, 16'h0000);
    chk({7'h0, rf_gain_loop_off}, 8'h00, "loop on again");
    $display("test gain done");
  endtask
  // Pin drive, levels, interrupt function and a bad opcode
  task automatic t_pins;
    wbc_host_i.cmd(8'h81, 16'h000A);
    wbc_host_i.cmd(8'h80, 16'h000E);
    chk({5'h0, out_pin_3_oe, out_pin_2_oe, out_pin_1_oe}, 8'h07, "oe");
    chk({5'h0, out_pin_3, out_pin_2, out_pin_1}, 8'h05, "levels");
    wbc_host_i.xfer(1'b1, 12'h018, 32'h1);
    wbc_host_i.cmd(8'h80, 16'h0002);
    chk({5'h0, out_pin_3_oe, out_pin_2_oe, out_pin_1_oe}, 8'h03, "irq oe");
    chk({7'h0, out_pin_2}, 8'h01, "irq idle high");
    wbc_host_i.cmd(8'h5A, 16'h0000);
    rsp(8'hC0, "bad opcode");
    wbc_host_i.cmd(8'h80, 16'h000E); // leave every pin driven
    rsp(8'h80, "err cleared");
    $display("test pins done");
  endtask
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_msg();
    t_tone();
    t_gain();
    t_pins();
    end_sim();
  end
  // Hang guard, well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("[FAIL] %0t watchdog", $time);
    end_sim();
  end
endmodule
